/* File: wake_pkg.sv */
// constants for the wake event enable block: register indices, fields, resets
// assumes byte address = index * 4 on a 32-bit apb bus with 12-bit addresses
package wake_pkg;

    localparam int GROUPS = 3;
    localparam int BYTE_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RESERVED = 8'h09;
    localparam logic [2:0][7:0] IDX_STATUS = {8'h06, 8'h05, 8'h04};
    localparam logic [2:0][7:0] IDX_ENABLE = {8'h0c, 8'h0b, 8'h0a};
    localparam logic [2:0][7:0] IDX_IRQ_MASK = {8'h16, 8'h15, 8'h14};
    localparam logic [7:0] IDX_CONTROL = 8'h10;

    // bits that exist in each group; bit 0 of the peripheral group is reserved
    localparam logic [2:0][7:0] GROUP_VALID = {8'hff, 8'hff, 8'hfe};

    // peripheral group bit positions
    localparam int POS_RING_PORT2 = 1;
    localparam int POS_RING_PORT1 = 2;
    localparam int POS_KEYBOARD = 3;
    localparam int POS_MOUSE = 4;
    localparam int POS_SPECIFIC_KEY = 5;
    localparam int POS_FAN1 = 6;
    localparam int POS_FAN2 = 7;

    // second gpio group: grouped device interrupt position
    localparam int POS_GROUPED_IRQ = 3;

    // control register field
    localparam int POS_GLOBAL_EN = 0;

    // reset values
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic GLOBAL_EN_RESET = 1'b0;

endpackage

/* File: wake_input_sync.sv */
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes asynchronous inputs; one pulse per filtered low-to-high change
`timescale 1ns/1ns
module wake_input_sync #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] rise_pulse
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] pulse;
    } sync_t;

    sync_t state_reg;
    sync_t state_next;
    logic [WIDTH-1:0] agree;

    // shift chain; level follows only when stages two and three agree
    always_comb begin
        state_next = state_reg;
        agree = ~(state_reg.s2 ^ state_reg.s3);
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.level = (state_reg.level & ~agree) | (state_reg.s3 & agree);
        state_next.pulse = state_next.level & ~state_reg.level;
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_pulse = state_reg.pulse;

endmodule

/* File: wake_status_bank.sv */
// eight sticky wake status bits, set by event pulses, cleared by write-one
// assumes set and clear are single-cycle pulses on pclk
`timescale 1ns/1ns
module wake_status_bank #(
    parameter logic [7:0] VALID = 8'hff
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] set_pulse,
    input wire logic [7:0] clear_mask,
    output logic [7:0] status
);

    typedef struct packed {
        logic [7:0] status;
    } bank_t;

    bank_t state_reg;
    bank_t state_next;

    // a set arriving with a clear wins; zeros in the clear mask keep bits
    always_comb begin
        state_next = state_reg;
        state_next.status = ((state_reg.status & ~clear_mask) | set_pulse) & VALID;
    end

    // of the resets, only the standby power-on reset clears the bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.status <= wake_pkg::STATUS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign status = state_reg.status;

endmodule

/* File: wake_event_enable_logic.sv */
// wake event enable logic: sticky wake status, per-source enables, wake request
// assumes an apb master on pclk; presetn is the standby power-on reset only
// Operation
// - write one clears status, zero leaves it
// - reserved register reads zero, ignores writes
// - wake needs enable, status and global enable
// - disabled source still latches status, no wake
// - enables reset to zero by standby reset only
// - peripheral enable bit layout, bit0 reserved
// - first gpio enable bits map pins ascending
// - second gpio enable with grouped interrupt bit3
// - status sets on event regardless of enables
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
module wake_event_enable_logic (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ring_indicate_port1,
    input wire logic ring_indicate_port2,
    input wire logic keyboard_wake,
    input wire logic mouse_wake,
    input wire logic specific_key_wake,
    input wire logic fan_speed_input1,
    input wire logic fan_speed_input2,
    input wire logic [7:0] gpio_a,
    input wire logic [2:0] gpio_b_low,
    input wire logic grouped_device_irq,
    input wire logic [3:0] gpio_b_high,
    output logic wake_request_out_n,
    output logic irq
);

    typedef struct packed {
        logic [2:0][7:0] enable;
        logic [2:0][7:0] irq_mask;
        logic global_wake_enable;
        logic [7:0] rdata;
        logic wake_req;
        logic irq_req;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [2:0][7:0] src_level;
    wire logic [2:0][7:0] set_evt;
    wire logic [2:0][7:0] clear_mask;
    wire logic [2:0][7:0] status;
    logic [2:0][7:0] qualified;
    logic [7:0] idx;
    logic [7:0] wr_byte;
    logic [7:0] rd_value;
    logic addr_ok;
    logic addr_hit;
    logic wr_fire;
    logic rd_setup;
    logic qual_any;

    // address split: word index plus alignment and range check
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign wr_byte = pwdata[7:0];

    // apb phases: reads captured in setup, writes taken in access
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_fire = psel && penable && pwrite && pstrb[0] && addr_hit;

    // zero-wait slave; error only for an unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // read mux and address decode
    always_comb begin
        rd_value = 8'h00;
        addr_hit = 1'b0;
        if (!addr_ok) begin
            addr_hit = 1'b0;
        end else if (idx == wake_pkg::IDX_STATUS[0]) begin
            addr_hit = 1'b1;
            rd_value = status[0];
        end else if (idx == wake_pkg::IDX_STATUS[1]) begin
            addr_hit = 1'b1;
            rd_value = status[1];
        end else if (idx == wake_pkg::IDX_STATUS[2]) begin
            addr_hit = 1'b1;
            rd_value = status[2];
        end else if (idx == wake_pkg::IDX_RESERVED) begin
            addr_hit = 1'b1;
            rd_value = 8'h00;
        end else if (idx == wake_pkg::IDX_ENABLE[0]) begin
            addr_hit = 1'b1;
            rd_value = state_reg.enable[0];
        end else if (idx == wake_pkg::IDX_ENABLE[1]) begin
            addr_hit = 1'b1;
            rd_value = state_reg.enable[1];
        end else if (idx == wake_pkg::IDX_ENABLE[2]) begin
            addr_hit = 1'b1;
            rd_value = state_reg.enable[2];
        end else if (idx == wake_pkg::IDX_CONTROL) begin
            addr_hit = 1'b1;
            rd_value[wake_pkg::POS_GLOBAL_EN] = state_reg.global_wake_enable;
        end else if (idx == wake_pkg::IDX_IRQ_MASK[0]) begin
            addr_hit = 1'b1;
            rd_value = state_reg.irq_mask[0];
        end else if (idx == wake_pkg::IDX_IRQ_MASK[1]) begin
            addr_hit = 1'b1;
            rd_value = state_reg.irq_mask[1];
        end else if (idx == wake_pkg::IDX_IRQ_MASK[2]) begin
            addr_hit = 1'b1;
            rd_value = state_reg.irq_mask[2];
        end
    end

    // wake source placement inside the three groups
    always_comb begin
        src_level = '0;
        src_level[0][wake_pkg::POS_RING_PORT2] = ring_indicate_port2;
        src_level[0][wake_pkg::POS_RING_PORT1] = ring_indicate_port1;
        src_level[0][wake_pkg::POS_KEYBOARD] = keyboard_wake;
        src_level[0][wake_pkg::POS_MOUSE] = mouse_wake;
        src_level[0][wake_pkg::POS_SPECIFIC_KEY] = specific_key_wake;
        src_level[0][wake_pkg::POS_FAN1] = fan_speed_input1;
        src_level[0][wake_pkg::POS_FAN2] = fan_speed_input2;
        src_level[1] = gpio_a;
        src_level[2][2:0] = gpio_b_low;
        src_level[2][wake_pkg::POS_GROUPED_IRQ] = grouped_device_irq;
        src_level[2][7:4] = gpio_b_high;
    end

    // per group: synchronise sources, hold sticky status, decode clears
    for (genvar g = 0; g < wake_pkg::GROUPS; g++) begin : g_group
        wake_input_sync #(
            .WIDTH(wake_pkg::BYTE_W)
        ) u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .async_in(src_level[g]),
            .rise_pulse(set_evt[g])
        );

        // status sets from the event alone, enables play no part
        wake_status_bank #(
            .VALID(wake_pkg::GROUP_VALID[g])
        ) u_bank (
            .pclk(pclk),
            .presetn(presetn),
            .set_pulse(set_evt[g]),
            .clear_mask(clear_mask[g]),
            .status(status[g])
        );

        assign clear_mask[g] = (wr_fire && idx == wake_pkg::IDX_STATUS[g]) ? wr_byte : 8'h00;
    end

    // qualification: enable and status per source, then global enable
    assign qualified = status & state_reg.enable;
    assign qual_any = |qualified;

    // register writes, read capture and output flops
    always_comb begin
        state_next = state_reg;
        if (rd_setup) begin
            state_next.rdata = rd_value;
        end
        if (wr_fire) begin
            if (idx == wake_pkg::IDX_ENABLE[0]) begin
                state_next.enable[0] = wr_byte & wake_pkg::GROUP_VALID[0];
            end else if (idx == wake_pkg::IDX_ENABLE[1]) begin
                state_next.enable[1] = wr_byte;
            end else if (idx == wake_pkg::IDX_ENABLE[2]) begin
                state_next.enable[2] = wr_byte;
            end else if (idx == wake_pkg::IDX_CONTROL) begin
                state_next.global_wake_enable = wr_byte[wake_pkg::POS_GLOBAL_EN];
            end else if (idx == wake_pkg::IDX_IRQ_MASK[0]) begin
                state_next.irq_mask[0] = wr_byte & wake_pkg::GROUP_VALID[0];
            end else if (idx == wake_pkg::IDX_IRQ_MASK[1]) begin
                state_next.irq_mask[1] = wr_byte;
            end else if (idx == wake_pkg::IDX_IRQ_MASK[2]) begin
                state_next.irq_mask[2] = wr_byte;
            end
        end
        state_next.wake_req = state_reg.global_wake_enable && qual_any;
        state_next.irq_req = |(status & state_reg.irq_mask);
    end

    // standby reset clears everything; other resets do not reach here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.enable <= {3{wake_pkg::ENABLE_RESET}};
            state_reg.irq_mask <= {3{wake_pkg::IRQ_MASK_RESET}};
            state_reg.global_wake_enable <= wake_pkg::GLOBAL_EN_RESET;
            state_reg.rdata <= 8'h00;
            state_reg.wake_req <= 1'b0;
            state_reg.irq_req <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs from flops; the wake line is active low
    assign prdata = {24'h000000, state_reg.rdata};
    assign wake_request_out_n = !state_reg.wake_req;
    assign irq = state_reg.irq_req;

    // checks on the design's own behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus phase and wake qualification sequences
    sequence s_rsvd_setup;
        rd_setup && addr_ok && idx == wake_pkg::IDX_RESERVED;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    sequence s_wake_qualified;
        state_reg.global_wake_enable && qual_any;
    endsequence

    sequence s_wake_blocked;
        !state_reg.global_wake_enable || !qual_any;
    endsequence

    // written ones clear unless a new event lands together
    property p_status_clear;
        (clear_mask != '0) |=> ((status & $past(clear_mask) & ~$past(set_evt)) == '0);
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status bit not cleared by written one");

    // bits not written with one and not set keep their value
    property p_status_keep;
        1'b1 |=> (((status ^ $past(status)) & ~$past(clear_mask) & ~$past(set_evt)) == '0);
    endproperty
    a_status_keep: assert property (p_status_keep)
        else $error("status bit changed without clear or event");

    // reserved register reads zero in the access phase
    property p_reserved_read;
        s_rsvd_setup ##1 s_access |-> (prdata == 32'h00000000);
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved register read not zero");

    // a write to the reserved register changes no control state
    property p_reserved_write;
        (wr_fire && idx == wake_pkg::IDX_RESERVED) |=>
            ($stable(state_reg.enable) && $stable(state_reg.irq_mask)
            && $stable(state_reg.global_wake_enable));
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("reserved write changed a register");

    // qualified source drives the wake line low the next cycle
    property p_wake_assert;
        s_wake_qualified |=> !wake_request_out_n;
    endproperty
    a_wake_assert: assert property (p_wake_assert)
        else $error("wake request not asserted for qualified source");

    // without enable, global enable or status the line stays high
    property p_wake_blocked;
        s_wake_blocked |=> wake_request_out_n;
    endproperty
    a_wake_blocked: assert property (p_wake_blocked)
        else $error("wake request asserted without qualification");

    // enables come out of standby reset at zero
    property p_enable_reset;
        $rose(presetn) |-> (state_reg.enable == '0);
    endproperty
    a_enable_reset: assert property (p_enable_reset)
        else $error("enable registers not zero after reset");

    // reserved enable bit never sets, the others take the write
    property p_enable0_write;
        (wr_fire && idx == wake_pkg::IDX_ENABLE[0]) |=>
            (state_reg.enable[0] == ($past(wr_byte) & 8'hfe));
    endproperty
    a_enable0_write: assert property (p_enable0_write)
        else $error("peripheral enable write wrong");

    property p_enable1_write;
        (wr_fire && idx == wake_pkg::IDX_ENABLE[1]) |=> (state_reg.enable[1] == $past(wr_byte));
    endproperty
    a_enable1_write: assert property (p_enable1_write)
        else $error("first gpio enable write wrong");

    // grouped interrupt event lands in status bit three of group two
    property p_grouped_irq_status;
        set_evt[2][3] |=> status[2][3];
    endproperty
    a_grouped_irq_status: assert property (p_grouped_irq_status)
        else $error("grouped interrupt event not latched");

    // an event sets its status bit whatever the enables say
    property p_status_set;
        (set_evt != '0) |=> ((status & $past(set_evt)) == $past(set_evt));
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("event did not set status");

    // once low, the wake line stays low unless a write lands now or just before
    // a write needs two edges to reach the registered wake line
    property p_wake_hold;
        (!wake_request_out_n && !wr_fire && !$past(wr_fire)) |=> !wake_request_out_n;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("wake request released without a write");

    // third enable register takes the whole written byte
    property p_enable2_write;
        (wr_fire && idx == wake_pkg::IDX_ENABLE[2]) |=> (state_reg.enable[2] == $past(wr_byte));
    endproperty
    a_enable2_write: assert property (p_enable2_write)
        else $error("second gpio enable write wrong");

    // reserved register answers without an error
    property p_reserved_no_err;
        (psel && penable && addr_ok && idx == wake_pkg::IDX_RESERVED) |-> !pslverr;
    endproperty
    a_reserved_no_err: assert property (p_reserved_no_err)
        else $error("reserved register access flagged an error");

    // global enable off keeps the wake line released
    property p_global_off;
        !state_reg.global_wake_enable |=> wake_request_out_n;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("wake request asserted with global enable off");

    // enables change only through a register write
    property p_enable_keep;
        !wr_fire |=> $stable(state_reg.enable);
    endproperty
    a_enable_keep: assert property (p_enable_keep)
        else $error("enable register changed without a write");

endmodule

/* File: wake_chipset_model.sv */
// chipset side of the wake request line: counts wake assertions
// assumes the wake line is a registered active-low level on pclk
`timescale 1ns/1ns
module wake_chipset_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wake_request_out_n,
    output logic [7:0] wake_seen
);
    logic last_n;

    // count each high-to-low change of the wake line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_n <= 1'b1;
            wake_seen <= 8'h00;
        end else begin
            last_n <= wake_request_out_n;
            if (last_n && !wake_request_out_n) begin
                wake_seen <= wake_seen + 8'h01;
            end
        end
    end
endmodule

/* File: wake_event_enable_logic_tb_top.sv */
// self-checking bench for the wake event enable block over apb
// assumes zero-wait apb slave and the chipset model on the wake line
`timescale 1ns/1ns
module wake_event_enable_logic_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0][7:0] src = '0;
    logic wake_request_out_n;
    logic irq;
    logic [7:0] wake_seen;
    logic [31:0] rdv;
    logic errv;
    int miscompares = 0;
    int n_tests = 0;

    wake_event_enable_logic i_wake_event_enable_logic (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ring_indicate_port1(src[0][2]), .ring_indicate_port2(src[0][1]),
        .keyboard_wake(src[0][3]), .mouse_wake(src[0][4]),
        .specific_key_wake(src[0][5]), .fan_speed_input1(src[0][6]),
        .fan_speed_input2(src[0][7]), .gpio_a(src[1]), .gpio_b_low(src[2][2:0]),
        .grouped_device_irq(src[2][3]), .gpio_b_high(src[2][7:4]),
        .wake_request_out_n(wake_request_out_n), .irq(irq)
    );

    wake_chipset_model i_wake_chipset_model (
        .pclk(pclk), .presetn(presetn), .wake_request_out_n(wake_request_out_n),
        .wake_seen(wake_seen)
    );

    // free-running 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        // idle edge first, so psel is never assigned twice in one time step
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            stop_test();
        end else begin
            rdv = prdata;
            errv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(what, {24'h0, exp}, rdv);
    endtask

    // one wake event on a source, long enough to pass the filter
    task automatic pulse(input int g, input int b);
        src[g][b] <= 1'b1;
        repeat (8) @(posedge pclk);
        src[g][b] <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    task automatic reset_dut();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    initial begin
        reset_dut();
        for (int g = 0; g < 3; g++) begin
            rchk("enable reset", adr(wake_pkg::IDX_ENABLE[g]), 8'h00);
            rchk("status reset", adr(wake_pkg::IDX_STATUS[g]), 8'h00);
        end
        // reserved place ignores writes, no error
        apb(1'b1, adr(wake_pkg::IDX_RESERVED), 8'hff);
        rchk("reserved", adr(wake_pkg::IDX_RESERVED), 8'h00);
        chk("reserved err", 32'h0, {31'h0, errv});
        apb(1'b0, 12'h0fc, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, errv});
        // enable registers hold what is written, reserved bit stays 0
        for (int g = 0; g < 3; g++) begin
            apb(1'b1, adr(wake_pkg::IDX_ENABLE[g]), 8'hff);
            rchk("enable rw", adr(wake_pkg::IDX_ENABLE[g]), wake_pkg::GROUP_VALID[g]);
            apb(1'b1, adr(wake_pkg::IDX_ENABLE[g]), 8'h00);
        end
        // write with the lane 0 strobe off leaves the register alone
        pstrb <= 4'h0;
        apb(1'b1, adr(wake_pkg::IDX_ENABLE[1]), 8'hff);
        pstrb <= 4'hf;
        rchk("strobe off", adr(wake_pkg::IDX_ENABLE[1]), 8'h00);
        // every source latches its own bit with enables off; w1c clears it
        apb(1'b1, adr(wake_pkg::IDX_CONTROL), 8'h01);
        for (int g = 0; g < 3; g++) begin
            for (int b = 0; b < 8; b++) begin
                if (wake_pkg::GROUP_VALID[g][b]) begin
                    pulse(g, b);
                    rchk("status set", adr(wake_pkg::IDX_STATUS[g]), 8'h01 << b);
                    chk("wake disabled", 32'h1, {31'h0, wake_request_out_n});
                    apb(1'b1, adr(wake_pkg::IDX_STATUS[g]), ~(8'h01 << b));
                    rchk("write zero", adr(wake_pkg::IDX_STATUS[g]), 8'h01 << b);
                    apb(1'b1, adr(wake_pkg::IDX_STATUS[g]), 8'h01 << b);
                    rchk("w1c", adr(wake_pkg::IDX_STATUS[g]), 8'h00);
                end
            end
        end
        // wake needs enable, status and global enable together
        apb(1'b1, adr(wake_pkg::IDX_ENABLE[2]), 8'h08);
        apb(1'b1, adr(wake_pkg::IDX_ENABLE[0]), 8'h02);
        pulse(2, wake_pkg::POS_GROUPED_IRQ);
        chk("wake on", 32'h0, {31'h0, wake_request_out_n});
        chk("chipset saw", 32'h1, {24'h0, wake_seen});
        apb(1'b1, adr(wake_pkg::IDX_CONTROL), 8'h00);
        repeat (3) @(posedge pclk);
        chk("global off", 32'h1, {31'h0, wake_request_out_n});
        apb(1'b1, adr(wake_pkg::IDX_CONTROL), 8'h01);
        pulse(0, wake_pkg::POS_RING_PORT2);
        chk("wake held", 32'h0, {31'h0, wake_request_out_n});
        apb(1'b1, adr(wake_pkg::IDX_STATUS[2]), 8'h08);
        repeat (3) @(posedge pclk);
        chk("wake or", 32'h0, {31'h0, wake_request_out_n});
        apb(1'b1, adr(wake_pkg::IDX_STATUS[0]), 8'h02);
        repeat (3) @(posedge pclk);
        chk("wake off", 32'h1, {31'h0, wake_request_out_n});
        // interrupt raised, masked and cleared
        apb(1'b1, adr(wake_pkg::IDX_IRQ_MASK[1]), 8'h80);
        pulse(1, 7);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, adr(wake_pkg::IDX_IRQ_MASK[1]), 8'h00);
        repeat (3) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, adr(wake_pkg::IDX_IRQ_MASK[1]), 8'h80);
        apb(1'b1, adr(wake_pkg::IDX_STATUS[1]), 8'h80);
        repeat (3) @(posedge pclk);
        chk("irq clear", 32'h0, {31'h0, irq});
        // standby reset in mid-run clears the enables
        apb(1'b1, adr(wake_pkg::IDX_ENABLE[1]), 8'h5a);
        reset_dut();
        rchk("enable rereset", adr(wake_pkg::IDX_ENABLE[1]), 8'h00);
        rchk("enable rereset", adr(wake_pkg::IDX_ENABLE[2]), 8'h00);
        stop_test();
    end

    // overall limit on run length
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
endmodule
